// ---- isu_pkg.sv ----
package isu_pkg;

    // register indices; the bus byte address is four times the index
    localparam logic [15:0] IDX_PRIO_A      = 16'hff20;
    localparam logic [15:0] IDX_PRIO_B      = 16'hff21;
    localparam logic [15:0] IDX_EN_TIMERS   = 16'hff22;
    localparam logic [15:0] IDX_EN_PORTS    = 16'hff23;
    localparam logic [15:0] IDX_FLAG_TIMERS = 16'hff24;
    localparam logic [15:0] IDX_FLAG_PORTS  = 16'hff25;
    localparam logic [15:0] IDX_PRIO_CONV   = 16'hff28;
    localparam logic [15:0] IDX_EN_CONV     = 16'hff2a;
    localparam logic [15:0] IDX_FLAG_CONV   = 16'hff2c;

    // source bit positions inside the 16-bit flag and enable vectors
    localparam int BIT_PT_B      = 7;
    localparam int BIT_PT_A      = 6;
    localparam int BIT_SW_100    = 14;
    localparam int BIT_TM_1      = 8;
    localparam int BIT_CONV      = 15;
    localparam logic [15:0] PORT_SRC_MASK = 16'h0038;

    // system numbers, each owning a two-bit priority field
    localparam logic [2:0] SYS_PT   = 3'h0;
    localparam logic [2:0] SYS_PAIR = 3'h1;
    localparam logic [2:0] SYS_OCT  = 3'h2;
    localparam logic [2:0] SYS_SER  = 3'h3;
    localparam logic [2:0] SYS_SW   = 3'h4;
    localparam logic [2:0] SYS_TM   = 3'h5;
    localparam logic [2:0] SYS_CONV = 3'h6;

    localparam logic [15:0] FLAGS_RST = 16'h0000;
    localparam logic [15:0] EN_RST    = 16'h0000;
    localparam logic [13:0] PRIO_RST  = 14'h0000;

    // low-speed oscillator periods waited after a wake from sleep
    localparam int SETTLE_PERIODS_DEF = 8192;
    localparam int SETTLE_CNT_MAX     = 16384;

    typedef enum logic [1:0] {
        ST_RUN    = 2'b00,
        ST_HALT   = 2'b01,
        ST_SLEEP  = 2'b10,
        ST_SETTLE = 2'b11
    } standby_t;

    typedef struct packed {
        logic prog_b_uf;
        logic prog_a_uf;
        logic ser_err;
        logic ser_rx;
        logic ser_tx;
        logic conv_done;
    } pulse_evt_t;

    typedef struct packed {
        logic [15:0] flags;
        logic [15:0] enables;
        logic [13:0] prio;
        logic [2:0]  sw_prev;
        logic [3:0]  tm_prev;
        logic [2:0]  mis_prev;
        logic        osc_prev;
        standby_t    stby;
        logic [13:0] cnt;
        logic        ack;
        logic [7:0]  dat;
        logic        irq_req;
        logic [1:0]  irq_lvl;
        logic [3:0]  irq_src;
        logic        cpu_off;
    } state_t;

    localparam state_t STATE_RST = '{
        flags: FLAGS_RST, enables: EN_RST, prio: PRIO_RST,
        sw_prev: 3'h0, tm_prev: 4'h0, mis_prev: 3'h0, osc_prev: 1'b0,
        stby: ST_RUN, cnt: 14'h0000, ack: 1'b0, dat: 8'h00,
        irq_req: 1'b0, irq_lvl: 2'h0, irq_src: 4'h0, cpu_off: 1'b0};

endpackage

// ---- interrupt_and_standby_unit.sv ----
// Implementation choice: the Wishbone slave port.
`timescale 1ns/100ps

// Operation
// R1: sixteen sources in seven systems, each with own pending flag and enable.
// R2: each system has a writable priority field choosing one of three levels.
// R3: a source event sets its pending flag, which stays until software clears.
// R4: writing one clears a pending flag; writing zero leaves it alone.
// R5: reset clears every pending flag.
// R6: one read/write enable bit per flag; one permits, zero blocks requests.
// R7: reset clears every enable bit.
// R8: request needs flag set, enable set, priority above the cpu mask.
// R9: the cpu samples requests at each instruction's first opcode fetch.
// R10: timer b and timer a underflows set bits 7 and 6 of ff25.
// R11: pin mismatch sets ff25 bit 5 pair, bit 4 upper, bit 3 lower.
// R12: serial error, receive done, transmit done set ff25 bits 2, 1, 0.
// R13: stopwatch 100, 10, 1 Hz falling edges set ff24 bits 6, 5, 4.
// R14: clock timer 32, 8, 2, 1 Hz rising edges set ff24 bits 3 to 0.
// R15: converter system has one source, conversion done, at ff2c bit 7.
// R16: eight-pin group gives two types, two-pin group gives one type.
// R17: halt stops the cpu only; reset or any request ends it.
// R18: sleep stops cpu and peripherals; only reset or port interrupt ends it.
// R19: on wake from sleep hold the cpu for 8192 low-speed oscillator periods.
// R20: after the wait the cpu resumes with the waking port interrupt.
// R21: software clears the serviced flag before return, else it re-raises.
// R22: priority codes 11, 10, 01, 00 give levels 3 to 0; zero never requests.
// R23: systems of equal level are ordered by a fixed default priority.
// R24: present highest level among active systems and the winning source id.
module interrupt_and_standby_unit #(
    parameter int SETTLE_PERIODS = isu_pkg::SETTLE_PERIODS_DEF
) (
    input  wire logic                REF_CLK,
    input  wire logic                RST,
    input  wire logic                WB_CYC_I,
    input  wire logic                WB_STB_I,
    input  wire logic                WB_WE_I,
    input  wire logic [17:0]         WB_ADR_I,
    input  wire logic [3:0]          WB_SEL_I,
    input  wire logic [31:0]         WB_DAT_I,
    output logic      [31:0]         WB_DAT_O,
    output logic                     WB_ACK_O,
    input  wire isu_pkg::pulse_evt_t EVT_PULSES,
    input  wire logic [2:0]          STOPWATCH_TAPS,
    input  wire logic [3:0]          CLOCK_TAPS,
    input  wire logic [7:0]          INPUT_PINS_GROUP_A,
    input  wire logic [1:0]          INPUT_PINS_GROUP_B,
    input  wire logic [3:0]          PIN_COMPARE_LOW_BITS,
    input  wire logic [3:0]          PIN_COMPARE_HIGH_BITS,
    input  wire logic [1:0]          PIN_COMPARE_PAIR_BITS,
    input  wire logic                CPU_MASK_BIT_LOW,
    input  wire logic                CPU_MASK_BIT_HIGH,
    input  wire logic                HALT_INSTRUCTION,
    input  wire logic                SLEEP_INSTRUCTION,
    input  wire logic                LOW_SPEED_OSCILLATOR,
    output logic                     IRQ_REQUEST,
    output logic      [1:0]          IRQ_LEVEL,
    output logic      [3:0]          IRQ_SOURCE,
    output logic                     CPU_STOPPED,
    output logic                     PERIPH_STOPPED
);

    // the settle counter is 14 bits wide inside the state record
    if (SETTLE_PERIODS < 1 || SETTLE_PERIODS > isu_pkg::SETTLE_CNT_MAX) begin
        $error("SETTLE_PERIODS out of range");
    end

    localparam logic [13:0] SETTLE_LAST = 14'(SETTLE_PERIODS - 1);
    localparam int          BIT_PT_B_L   = isu_pkg::BIT_PT_B;
    localparam int          BIT_PT_A_L   = isu_pkg::BIT_PT_A;
    localparam int          BIT_SW_100_L = isu_pkg::BIT_SW_100;
    localparam int          BIT_TM_1_L   = isu_pkg::BIT_TM_1;

    isu_pkg::state_t st_r;
    isu_pkg::state_t st_nxt;
    logic            hit;
    logic            wr;
    logic [15:0]     idx;
    logic [7:0]      wbyte;
    logic [7:0]      rd;
    logic [15:0]     clr;
    logic [15:0]     set;
    logic [15:0]     act;
    logic [2:0]      sw_fall;
    logic [3:0]      tm_rise;
    logic [2:0]      mis;
    logic [2:0]      mis_rise;
    logic            periph_stop;
    logic            osc_rise;
    logic [1:0]      cpu_mask;
    logic [1:0]      best_lvl;
    logic [3:0]      best_rank;
    logic            req;
    logic            port_wake;

    // fixed default order: rank 0 is timer b, rank 15 the converter
    function automatic logic [3:0] src_of_rank(input int rank);
        if (rank < 8)
            return 4'(7 - rank);
        else if (rank < 15)
            return 4'(22 - rank);
        else
            return 4'(isu_pkg::BIT_CONV);
    endfunction

    // which system a flag bit belongs to
    function automatic logic [2:0] sys_of(input logic [3:0] b);
        case (b)
            4'h7, 4'h6:               return isu_pkg::SYS_PT;
            4'h5:                     return isu_pkg::SYS_PAIR;
            4'h4, 4'h3:               return isu_pkg::SYS_OCT;
            4'h2, 4'h1, 4'h0:         return isu_pkg::SYS_SER;
            4'he, 4'hd, 4'hc:         return isu_pkg::SYS_SW;
            4'hb, 4'ha, 4'h9, 4'h8:   return isu_pkg::SYS_TM;
            default:                  return isu_pkg::SYS_CONV;
        endcase
    endfunction

    // programmed level of the system that owns flag bit b
    function automatic logic [1:0] lvl_of(input logic [13:0] prio,
                                          input logic [3:0]  b);
        logic [2:0] s;
        s = sys_of(b);
        return prio[{s, 1'b0} +: 2];
    endfunction

    // qualifying terms from the live inputs and the registered state
    assign cpu_mask    = {CPU_MASK_BIT_HIGH, CPU_MASK_BIT_LOW};
    assign periph_stop = st_r.stby == isu_pkg::ST_SLEEP ||
                         st_r.stby == isu_pkg::ST_SETTLE;
    assign act         = st_r.flags & st_r.enables;            // [R8]
    assign sw_fall     = st_r.sw_prev & ~STOPWATCH_TAPS;        // [R13]
    assign tm_rise     = CLOCK_TAPS & ~st_r.tm_prev;            // [R14]
    assign osc_rise    = LOW_SPEED_OSCILLATOR & ~st_r.osc_prev;
    assign port_wake   = |(act & isu_pkg::PORT_SRC_MASK);       // [R18]

    // pair, upper nibble, lower nibble mismatch against compare bits
    assign mis[2]   = |(INPUT_PINS_GROUP_B ^ PIN_COMPARE_PAIR_BITS);
    assign mis[1]   = |(INPUT_PINS_GROUP_A[7:4] ^ PIN_COMPARE_HIGH_BITS);
    assign mis[0]   = |(INPUT_PINS_GROUP_A[3:0] ^ PIN_COMPARE_LOW_BITS);
    assign mis_rise = mis & ~st_r.mis_prev;                     // [R11] [R16]

    // event sets; only the port sources keep working while asleep
    always_comb begin
        set = {EVT_PULSES.conv_done,                             // [R15]
               sw_fall,                                          // [R13]
               tm_rise,                                          // [R14]
               EVT_PULSES.prog_b_uf, EVT_PULSES.prog_a_uf,       // [R10]
               mis_rise,                                         // [R11]
               EVT_PULSES.ser_err, EVT_PULSES.ser_rx,            // [R12]
               EVT_PULSES.ser_tx};
        if (periph_stop) begin
            set = set & isu_pkg::PORT_SRC_MASK;                  // [R18]
        end
    end

    // highest level wins; strict compare keeps the earlier rank on ties
    always_comb begin
        best_lvl  = 2'h0;
        best_rank = 4'h0;
        for (int r = 0; r < 16; r++) begin
            if (act[src_of_rank(r)] &&
                lvl_of(st_r.prio, src_of_rank(r)) > best_lvl) begin
                best_lvl  = lvl_of(st_r.prio, src_of_rank(r));   // [R24]
                best_rank = 4'(r);                               // [R23]
            end
        end
        req = best_lvl > cpu_mask;                               // [R8] [R22]
    end

    // bus decode, register file and standby sequencer
    always_comb begin
        st_nxt = st_r;
        hit    = WB_CYC_I & WB_STB_I & ~st_r.ack;
        wr     = hit & WB_WE_I & WB_SEL_I[0];
        idx    = WB_ADR_I[17:2];
        wbyte  = WB_DAT_I[7:0];
        clr    = 16'h0000;
        rd     = 8'h00;
        case (idx)
            isu_pkg::IDX_PRIO_A: begin
                rd = {st_r.prio[5:4], st_r.prio[7:6],
                      st_r.prio[9:8], st_r.prio[11:10]};
                if (wr) begin
                    st_nxt.prio[5:4]   = wbyte[7:6];             // [R2]
                    st_nxt.prio[7:6]   = wbyte[5:4];
                    st_nxt.prio[9:8]   = wbyte[3:2];
                    st_nxt.prio[11:10] = wbyte[1:0];
                end
            end
            isu_pkg::IDX_PRIO_B: begin
                rd = {4'h0, st_r.prio[1:0], st_r.prio[3:2]};
                if (wr) begin
                    st_nxt.prio[1:0] = wbyte[3:2];               // [R2]
                    st_nxt.prio[3:2] = wbyte[1:0];
                end
            end
            isu_pkg::IDX_PRIO_CONV: begin
                rd = {st_r.prio[13:12], 6'h00};
                if (wr) begin
                    st_nxt.prio[13:12] = wbyte[7:6];             // [R2]
                end
            end
            isu_pkg::IDX_EN_TIMERS: begin
                rd = {1'b0, st_r.enables[14:8]};                 // [R6]
                if (wr) begin
                    st_nxt.enables[14:8] = wbyte[6:0];
                end
            end
            isu_pkg::IDX_EN_PORTS: begin
                rd = st_r.enables[7:0];                          // [R6]
                if (wr) begin
                    st_nxt.enables[7:0] = wbyte;
                end
            end
            isu_pkg::IDX_EN_CONV: begin
                rd = {st_r.enables[15], 7'h00};                  // [R6]
                if (wr) begin
                    st_nxt.enables[15] = wbyte[7];
                end
            end
            isu_pkg::IDX_FLAG_TIMERS: begin
                rd = {1'b0, st_r.flags[14:8]};                   // [R3]
                if (wr) begin
                    clr[14:8] = wbyte[6:0];                      // [R4]
                end
            end
            isu_pkg::IDX_FLAG_PORTS: begin
                rd = st_r.flags[7:0];                            // [R3]
                if (wr) begin
                    clr[7:0] = wbyte;                            // [R4]
                end
            end
            isu_pkg::IDX_FLAG_CONV: begin
                rd = {st_r.flags[15], 7'h00};                    // [R15]
                if (wr) begin
                    clr[15] = wbyte[7];                          // [R4]
                end
            end
            default: rd = 8'h00;         // unmapped reads zero, still acked
        endcase
        st_nxt.ack = hit;
        st_nxt.dat = hit ? rd : 8'h00;

        // a set arriving with its clear wins, so no event is lost
        st_nxt.flags    = (st_r.flags & ~clr) | set;             // [R1] [R3]
        st_nxt.sw_prev  = STOPWATCH_TAPS;
        st_nxt.tm_prev  = CLOCK_TAPS;
        st_nxt.mis_prev = mis;
        st_nxt.osc_prev = LOW_SPEED_OSCILLATOR;

        // cpu-facing request, one cycle behind the flags
        st_nxt.irq_req = req;                                    // [R8]
        st_nxt.irq_lvl = best_lvl;                               // [R24]
        st_nxt.irq_src = best_rank;                              // [R24]

        case (st_r.stby)
            isu_pkg::ST_RUN: begin
                if (SLEEP_INSTRUCTION) begin
                    st_nxt.stby = isu_pkg::ST_SLEEP;             // [R18]
                end else if (HALT_INSTRUCTION) begin
                    st_nxt.stby = isu_pkg::ST_HALT;              // [R17]
                end
            end
            isu_pkg::ST_HALT: begin
                if (req) begin
                    st_nxt.stby = isu_pkg::ST_RUN;               // [R17]
                end
            end
            isu_pkg::ST_SLEEP: begin
                if (port_wake) begin
                    st_nxt.stby = isu_pkg::ST_SETTLE;            // [R18]
                    st_nxt.cnt  = 14'h0000;
                end
            end
            isu_pkg::ST_SETTLE: begin
                // the waking port flag stays pending and is taken on resume
                if (osc_rise) begin
                    if (st_r.cnt == SETTLE_LAST) begin
                        st_nxt.stby = isu_pkg::ST_RUN;           // [R19] [R20]
                    end else begin
                        st_nxt.cnt = st_r.cnt + 14'h0001;        // [R19]
                    end
                end
            end
            default: st_nxt.stby = isu_pkg::ST_RUN;
        endcase
        st_nxt.cpu_off = st_nxt.stby != isu_pkg::ST_RUN; // stop output flop
    end

    // single state register
    always_ff @(posedge REF_CLK) begin
        if (RST) begin
            st_r <= isu_pkg::STATE_RST;                          // [R5] [R7]
        end else begin
            st_r <= st_nxt;
        end
    end

    // every output taken straight from the state register
    assign WB_ACK_O       = st_r.ack;
    assign WB_DAT_O       = {24'h000000, st_r.dat};
    assign IRQ_REQUEST    = st_r.irq_req;  // cpu samples it at fetch [R9]
    assign IRQ_LEVEL      = st_r.irq_lvl;
    assign IRQ_SOURCE     = st_r.irq_src;
    assign CPU_STOPPED    = st_r.cpu_off;
    assign PERIPH_STOPPED = st_r.stby[1];  // sleep and settle share bit 1

    sequence s_enter_settle;
        st_r.stby == isu_pkg::ST_SLEEP ##1 st_r.stby == isu_pkg::ST_SETTLE;
    endsequence
    sequence s_bus_answer;
        WB_ACK_O ##1 !WB_ACK_O;
    endsequence

    a_bus_ack_once: assert property (@(posedge REF_CLK) disable iff (RST)
        (WB_CYC_I && WB_STB_I && !WB_ACK_O) |=> s_bus_answer)
        else $error("bus ack not a single cycle after request");
    a_flag_sets: assert property (@(posedge REF_CLK) disable iff (RST) // [R10]
        (EVT_PULSES.prog_b_uf && !periph_stop) |=> st_r.flags[BIT_PT_B_L])
        else $error("timer b underflow did not set its flag");
    a_flag_holds: assert property (@(posedge REF_CLK) disable iff (RST) // [R3]
        (st_r.flags[BIT_PT_A_L] && !clr[BIT_PT_A_L])
        |=> st_r.flags[BIT_PT_A_L])
        else $error("pending flag dropped without a clear");
    a_flag_w1c: assert property (@(posedge REF_CLK) disable iff (RST) // [R4]
        (st_r.flags[BIT_PT_A_L] && clr[BIT_PT_A_L] && !set[BIT_PT_A_L])
        |=> !st_r.flags[BIT_PT_A_L])
        else $error("write of one did not clear the flag");
    a_reset_clears: assert property (@(posedge REF_CLK) // [R5] [R7]
        RST |=> (st_r.flags == 16'h0000 && st_r.enables == 16'h0000 &&
                 st_r.prio == 14'h0000))
        else $error("flags, enables or priorities not zero after reset");
    a_enable_store: assert property (@(posedge REF_CLK) disable iff (RST)
        (wr && idx == isu_pkg::IDX_EN_PORTS)                        // [R6]
        |=> st_r.enables[7:0] == $past(wbyte))
        else $error("enable write not stored");
    a_req_above_mask: assert property (@(posedge REF_CLK) disable iff (RST)
        IRQ_REQUEST |-> (IRQ_LEVEL > $past(cpu_mask) &&             // [R8]
                         IRQ_LEVEL != 2'h0))
        else $error("request raised at or below the cpu mask");
    a_winner_active: assert property (@(posedge REF_CLK) disable iff (RST)
        (IRQ_LEVEL != 2'h0) |-> $past(act[src_of_rank(best_rank)])) // [R24]
        else $error("reported source was not active");
    a_stopwatch_edge: assert property (@(posedge REF_CLK) disable iff (RST)
        ($fell(STOPWATCH_TAPS[2]) && !$past(RST) && !periph_stop)   // [R13]
        |=> st_r.flags[BIT_SW_100_L])
        else $error("stopwatch falling edge missed");
    a_clock_edge: assert property (@(posedge REF_CLK) disable iff (RST)
        ($rose(CLOCK_TAPS[0]) && !$past(RST) && !periph_stop)       // [R14]
        |=> st_r.flags[BIT_TM_1_L])
        else $error("clock timer rising edge missed");
    a_halt_wake: assert property (@(posedge REF_CLK) disable iff (RST)
        (st_r.stby == isu_pkg::ST_HALT && req)                      // [R17]
        |=> st_r.stby == isu_pkg::ST_RUN)
        else $error("halt not ended by a request");
    a_sleep_holds: assert property (@(posedge REF_CLK) disable iff (RST)
        (st_r.stby == isu_pkg::ST_SLEEP && !port_wake)              // [R18]
        |=> st_r.stby == isu_pkg::ST_SLEEP)
        else $error("sleep left without a port interrupt");
    a_settle_starts: assert property (@(posedge REF_CLK) disable iff (RST)
        s_enter_settle |-> st_r.cnt == 14'h0000)                    // [R19]
        else $error("settle count not started at zero");
    a_settle_wait: assert property (@(posedge REF_CLK) disable iff (RST)
        (st_r.stby == isu_pkg::ST_SETTLE &&                         // [R19]
         !(osc_rise && st_r.cnt == SETTLE_LAST))
        |=> st_r.stby == isu_pkg::ST_SETTLE)
        else $error("cpu released before the settle wait ended");

endmodule // interrupt_and_standby_unit

// ---- cpu_model.sv ----
`timescale 1ns/100ps

// stands in for the cpu core: mask flags, standby opcodes, fetch sampling
module cpu_model (
    input  wire logic       clk,
    input  wire logic       rst,
    input  wire logic       irq_request,
    input  wire logic       cpu_stopped,
    input  wire logic [1:0] mask_set,
    input  wire logic       halt_go,
    input  wire logic       sleep_go,
    output logic            mask_low,
    output logic            mask_high,
    output logic            halt_pulse,
    output logic            sleep_pulse
);
    int taken;

    // opcodes only issue while the core runs, so a stopped core sends none
    assign halt_pulse  = halt_go & ~cpu_stopped;
    assign sleep_pulse = sleep_go & ~cpu_stopped;
    assign {mask_high, mask_low} = mask_set;

    // every running cycle counts as a first opcode fetch
    always @(posedge clk) begin
        if (rst) begin
            taken <= 0;
        end else if (!cpu_stopped && irq_request === 1'b1) begin
            taken <= taken + 1;
        end
    end
endmodule // cpu_model

// ---- testbench.sv ----
`timescale 1ns/100ps
`define CHK(nm, e, g) begin n_checks++; if ((g) !== (e)) begin failures++; \
    $display("unexpected %s exp %h got %h", nm, e, g); end end

module testbench;
    logic        clk = 0, rst = 1, cyc = 0, stb = 0, we = 0, osc = 0;
    logic        halt_go = 0, sleep_go = 0, ack, irq, stopped, pstopped;
    logic        mlo, mhi, hp, sp;
    logic [17:0] adr = 0;
    logic [31:0] wdat = 0, rdat;
    logic [1:0]  mask_set = 0, lvl, pb = 0;
    logic [2:0]  swtap = 0;
    logic [3:0]  ctap = 0, src, cmp_hi = 0;
    logic [7:0]  pa = 0, v, e;
    logic [7:0]  exp_q[$];
    isu_pkg::pulse_evt_t evt = '0;
    int          failures = 0, n_checks = 0, seed = 44676;
    logic [15:0] idx[10] = '{16'hff20, 16'hff21, 16'hff22, 16'hff23,
        16'hff28, 16'hff2a, 16'hff24, 16'hff25, 16'hff2c, 16'hff30};
    logic [7:0]  msk[6] = '{8'hff, 8'h0f, 8'h7f, 8'hff, 8'hc0, 8'h80};
    logic [7:0]  arm[6] = '{8'haa, 8'h0a, 8'h7f, 8'hff, 8'h80, 8'h80};

    always #25 clk = ~clk;

    interrupt_and_standby_unit #(.SETTLE_PERIODS(4)) dut (
        .REF_CLK(clk), .RST(rst), .WB_CYC_I(cyc), .WB_STB_I(stb),
        .WB_WE_I(we), .WB_ADR_I(adr), .WB_SEL_I(4'hf), .WB_DAT_I(wdat),
        .WB_DAT_O(rdat), .WB_ACK_O(ack), .EVT_PULSES(evt),
        .STOPWATCH_TAPS(swtap), .CLOCK_TAPS(ctap), .INPUT_PINS_GROUP_A(pa),
        .INPUT_PINS_GROUP_B(pb), .PIN_COMPARE_LOW_BITS(4'h0),
        .PIN_COMPARE_HIGH_BITS(cmp_hi), .PIN_COMPARE_PAIR_BITS(2'h0),
        .CPU_MASK_BIT_LOW(mlo), .CPU_MASK_BIT_HIGH(mhi),
        .HALT_INSTRUCTION(hp), .SLEEP_INSTRUCTION(sp),
        .LOW_SPEED_OSCILLATOR(osc), .IRQ_REQUEST(irq), .IRQ_LEVEL(lvl),
        .IRQ_SOURCE(src), .CPU_STOPPED(stopped), .PERIPH_STOPPED(pstopped));

    cpu_model core (
        .clk(clk), .rst(rst), .irq_request(irq), .cpu_stopped(stopped),
        .mask_set(mask_set), .halt_go(halt_go), .sleep_go(sleep_go),
        .mask_low(mlo), .mask_high(mhi), .halt_pulse(hp), .sleep_pulse(sp));

    task automatic give_verdict();
        if (failures == 0 && n_checks > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask

    task automatic tick(input int n);
        repeat (n) @(posedge clk);
    endtask

    // one classic cycle; a read notes its expected byte for the monitor
    task automatic wb(input logic w, input logic [15:0] i,
                      input logic [7:0] d);
        int n;
        n = 0;
        if (!w) exp_q.push_back(d);
        cyc <= 1;
        stb <= 1;
        we <= w;
        adr <= {i, 2'b00};
        wdat <= {24'h0, d};
        @(posedge clk);
        while (ack !== 1'b1 && n < 20) begin
            @(posedge clk);
            n++;
        end
        if (ack !== 1'b1) begin
            failures++;
            give_verdict();
        end
        cyc <= 0;
        stb <= 0;
        @(posedge clk);
    endtask

    // bounded wait for the core to run again
    task automatic wait_run();
        int n;
        n = 0;
        while (stopped !== 1'b0 && n < 40) begin
            @(posedge clk);
            n++;
        end
        if (stopped !== 1'b0) begin
            failures++;
            give_verdict();
        end
    endtask

    // read data is judged at the ack edge, oldest note first
    always @(posedge clk) begin
        if (ack === 1'b1 && we === 1'b0) begin
            e = exp_q.pop_front();
            `CHK("read data", {24'h0, e}, rdat)
        end
    end

    initial begin
        tick(12);
        rst <= 0;
        @(posedge clk);
        // all cleared after reset, the unmapped place reads zero
        foreach (idx[k]) wb(0, idx[k], 8'h00);
        for (int k = 0; k < 6; k++) begin
            v = 8'($random(seed));
            wb(1, idx[k], v);
            wb(0, idx[k], v & msk[k]);
        end
        foreach (arm[k]) wb(1, idx[k], arm[k]);
        // fire every source once; taps make one edge of the right sense
        evt <= 6'h3f;
        swtap <= 3'h7;
        ctap <= 4'hf;
        @(posedge clk);
        evt <= 6'h00;
        swtap <= 3'h0;
        pa <= 8'hff;
        pb <= 2'h3;
        tick(2);
        wb(0, 16'hff24, 8'h7f);
        wb(0, 16'hff25, 8'hff);
        wb(0, 16'hff2c, 8'h80);
        mask_set <= 2'h1;
        tick(3);
        `CHK("level", 2'h2, lvl)
        `CHK("source", 4'h0, src)
        `CHK("request", 1'b1, irq)
        mask_set <= 2'h2;
        tick(3);
        `CHK("request", 1'b0, irq)
        wb(1, 16'hff21, 8'h0e);
        tick(2);
        `CHK("level", 2'h3, lvl)
        wb(1, 16'hff21, 8'h02);
        tick(2);
        `CHK("source", 4'h2, src)
        wb(1, 16'hff25, 8'h0f);
        wb(0, 16'hff25, 8'hf0);
        wb(1, 16'hff24, 8'h00);
        wb(0, 16'hff24, 8'h7f);
        wb(1, 16'hff25, 8'hff);
        wb(1, 16'hff24, 8'h7f);
        tick(2);
        `CHK("source", 4'hf, src)
        // halt, then a converter event wakes the core
        wb(1, 16'hff2c, 8'h80);
        mask_set <= 2'h0;
        halt_go <= 1;
        @(posedge clk);
        halt_go <= 0;
        tick(2);
        `CHK("stopped", 1'b1, stopped)
        evt <= 6'h01;
        @(posedge clk);
        evt <= 6'h00;
        wait_run();
        `CHK("request", 1'b1, irq)
        `CHK("fetch sample", 1'b1, core.taken > 0)
        wb(1, 16'hff2c, 8'h80);
        pa <= 8'h00;
        pb <= 2'h0;
        tick(2);
        `CHK("request", 1'b0, irq)
        // sleep: peripheral events ignored, only a pin onset wakes
        sleep_go <= 1;
        @(posedge clk);
        sleep_go <= 0;
        evt <= 6'h3f;
        tick(2);
        evt <= 6'h00;
        `CHK("asleep", 2'h3, {stopped, pstopped})
        pa <= 8'h01;
        tick(3);
        for (int k = 1; k <= 4; k++) begin
            `CHK("held", 1'b1, stopped)
            osc <= 1;
            tick(2);
            osc <= 0;
            tick(2);
        end
        wait_run();
        `CHK("wake source", 4'h4, src)
        wb(0, 16'hff25, 8'h08);
        wb(0, 16'hff2c, 8'h00);
        // upper nibble now differs from its compare bits
        cmp_hi <= 4'h5;
        tick(1);
        wb(0, 16'hff25, 8'h18);
        give_verdict();
    end
endmodule // testbench
